// ### ioc_pkg.sv
`default_nettype none
package ioc_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] IOC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] IOC_DELAY_ADDR = 8'h04;
  localparam logic [7:0] IOC_INVERT_ADDR = 8'h08;
  localparam logic [7:0] IOC_SECFG_ADDR = 8'h0c;
  localparam logic [7:0] IOC_STATUS_ADDR = 8'h10;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int IOC_CTRL_LOCK_BIT = 0;
  localparam int IOC_CTRL_IN_REG_BIT = 1;
  localparam int IOC_CTRL_OUT_REG_BIT = 2;
  localparam int IOC_CTRL_TRI_REG_BIT = 3;
  localparam int IOC_CTRL_OUT_LOWER_BIT = 4;
  localparam int IOC_CTRL_CE_USED_BIT = 5;
  localparam int IOC_CTRL_W = 8;
  localparam int IOC_DLY_ASYNC_LSB = 0;
  localparam int IOC_DLY_SYNC_LSB = 4;
  localparam int IOC_INV_W = 13;
  localparam int IOC_SE_FIELD_W = 3;
  localparam int IOC_SE_COUNT = 6;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [IOC_CTRL_W-1:0] IOC_CTRL_RST = 8'h00;
  localparam logic [3:0] IOC_ASYNC_RST = 4'h0;
  localparam logic [2:0] IOC_SYNC_RST = 3'h7;
  localparam logic [IOC_INV_W-1:0] IOC_INV_RST = 13'h0000;
  // ****************************************
  // Delay line figures
  // ****************************************
  localparam logic [3:0] IOC_ASYNC_MAX = 4'hc;
  localparam logic [3:0] IOC_ASYNC_HALF = 4'h6;
  localparam logic [2:0] IOC_SYNC_MAX = 3'h6;
  localparam logic [2:0] IOC_SYNC_HALF = 3'h3;
  localparam logic [2:0] IOC_SYNC_AUTO = 3'h7;
  localparam logic [2:0] IOC_SYNC_AUTO_STEP = 3'h3;
  localparam int IOC_TAPS = 6;
  localparam int IOC_COARSE_STAGES = 4;
  localparam int IOC_LINE_LEN = IOC_COARSE_STAGES + IOC_TAPS;
  // ****************************************
  // Inversion bit indices
  // ****************************************
  localparam int IOC_INV_OUT_UP = 0;
  localparam int IOC_INV_OUT_LO = 1;
  localparam int IOC_INV_TRI_UP = 2;
  localparam int IOC_INV_TRI_LO = 3;
  localparam int IOC_INV_ICLK_UP = 4;
  localparam int IOC_INV_ICLK_LO = 5;
  localparam int IOC_INV_OCLK_UP = 6;
  localparam int IOC_INV_OCLK_LO = 7;
  localparam int IOC_INV_ICE = 8;
  localparam int IOC_INV_OCE = 9;
  localparam int IOC_INV_TCE = 10;
  localparam int IOC_INV_SR = 11;
  localparam int IOC_INV_REV = 12;

  typedef struct packed {
    logic latch;
    logic sync_sr;
    logic sr_high;
  } ioc_se_cfg_t;
endpackage
`default_nettype wire

// ### ioc_store.sv
`default_nettype none
module ioc_store
  import ioc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  input wire logic en_in,
  input wire logic set_reset_line_in,
  input wire logic opposite_force_line_in,
  input wire ioc_se_cfg_t cfg_in,
  output logic q_out
);
  logic q_reg;
  logic force_on;
  logic force_val;

  assign force_on = set_reset_line_in | opposite_force_line_in;
  // Both forces together give zero
  assign force_val = (set_reset_line_in & opposite_force_line_in) ? 1'b0 :
                     (set_reset_line_in ? cfg_in.sr_high : ~cfg_in.sr_high);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_reg <= 1'b0;
    end else if (force_on) begin
      q_reg <= force_val;
    end else if (en_in) begin
      q_reg <= d_in;
    end
  end

  // Latch mode is transparent while enabled; flop mode shows the stored bit
  always_comb begin
    if (force_on && !cfg_in.sync_sr) begin
      q_out = force_val;
    end else if (cfg_in.latch && en_in && !force_on) begin
      q_out = d_in;
    end else begin
      q_out = q_reg;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_both_force_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (set_reset_line_in && opposite_force_line_in) |=> (q_reg == 1'b0))
    else $error("both forces did not store zero");
endmodule
`default_nettype wire

// ### ioc_cell.sv
// The implementer's own choices: the register addresses and register access over APB.
`default_nettype none
module ioc_cell
  import ioc_pkg::*;
#(
  parameter bit INPUT_ONLY = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_out,
  input wire logic output_data_upper_in,
  input wire logic output_data_lower_in,
  input wire logic drive_control_upper_in,
  input wire logic drive_control_lower_in,
  input wire logic in_clk_upper_en_in,
  input wire logic in_clk_lower_en_in,
  input wire logic out_clk_upper_en_in,
  input wire logic out_clk_lower_en_in,
  input wire logic in_ce_in,
  input wire logic out_ce_in,
  input wire logic tri_ce_in,
  input wire logic set_reset_line_in,
  input wire logic opposite_force_line_in,
  output logic input_direct_out,
  output logic input_capture_upper_out,
  output logic input_capture_lower_out
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [IOC_CTRL_W-1:0] ctrl_reg;
  logic [3:0] async_reg;
  logic [2:0] sync_reg;
  logic [IOC_INV_W-1:0] inv_reg;
  ioc_se_cfg_t [IOC_SE_COUNT-1:0] secfg_reg;
  logic locked;
  logic wr_access;
  logic addr_cfg;
  logic addr_known;
  logic [3:0] async_wr;

  assign locked = ctrl_reg[IOC_CTRL_LOCK_BIT];
  assign wr_access = psel_in && penable_in && pwrite_in;
  assign addr_cfg = (paddr_in == IOC_CTRL_ADDR) || (paddr_in == IOC_DELAY_ADDR) ||
                    (paddr_in == IOC_INVERT_ADDR) || (paddr_in == IOC_SECFG_ADDR);
  assign addr_known = addr_cfg || (paddr_in == IOC_STATUS_ADDR);
  // Out-of-range direct settings saturate at the top step
  assign async_wr = (pwdata_in[IOC_DLY_ASYNC_LSB +: 4] > IOC_ASYNC_MAX) ?
                    IOC_ASYNC_MAX : pwdata_in[IOC_DLY_ASYNC_LSB +: 4];

  // Lock is one-way: only reset reopens configuration
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= IOC_CTRL_RST;
    end else if (wr_access && !locked && paddr_in == IOC_CTRL_ADDR) begin
      ctrl_reg <= pwdata_in[IOC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      async_reg <= IOC_ASYNC_RST;
      sync_reg <= IOC_SYNC_RST;
    end else if (wr_access && !locked && paddr_in == IOC_DELAY_ADDR) begin
      async_reg <= async_wr;
      sync_reg <= pwdata_in[IOC_DLY_SYNC_LSB +: 3];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      inv_reg <= IOC_INV_RST;
      secfg_reg <= '0;
    end else if (wr_access && !locked) begin
      if (paddr_in == IOC_INVERT_ADDR) begin
        inv_reg <= pwdata_in[IOC_INV_W-1:0];
      end
      if (paddr_in == IOC_SECFG_ADDR) begin
        secfg_reg <= pwdata_in[IOC_SE_COUNT*IOC_SE_FIELD_W-1:0];
      end
    end
  end

  // ****************************************
  // Pad input and delay line
  // ****************************************
  logic pad_meta_reg;
  logic pad_sync_reg;
  logic [IOC_LINE_LEN-1:0] line_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pad_meta_reg <= 1'b0;
      pad_sync_reg <= 1'b0;
    end else begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      line_reg <= '0;
    end else begin
      line_reg <= {line_reg[IOC_LINE_LEN-2:0], pad_sync_reg};
    end
  end

  logic [2:0] sync_eff;
  logic coarse_use;
  logic [2:0] async_tap;
  logic [2:0] sync_tap;
  logic [3:0] async_idx;
  logic [3:0] sync_idx;
  logic direct_bit;
  logic delayed_sync_bit;
  logic half_mismatch;

  assign sync_eff = (sync_reg == IOC_SYNC_AUTO) ? IOC_SYNC_AUTO_STEP :
                    ((sync_reg > IOC_SYNC_MAX) ? IOC_SYNC_MAX : sync_reg);
  // One coarse stage serves both routes; the direct setting decides when set
  assign coarse_use = (async_reg != 4'h0) ? (async_reg > IOC_ASYNC_HALF) :
                      (sync_eff > IOC_SYNC_HALF);
  assign async_tap = (async_reg > IOC_ASYNC_HALF) ? 3'(async_reg - IOC_ASYNC_HALF) : async_reg[2:0];
  // Registered route reaches only every second tap
  assign sync_tap = (sync_eff > IOC_SYNC_HALF) ? 3'((sync_eff - IOC_SYNC_HALF) << 1) :
                    3'(sync_eff << 1);
  assign async_idx = coarse_use ? 4'(IOC_COARSE_STAGES + async_tap - 1) : 4'(async_tap - 1);
  assign sync_idx = coarse_use ? 4'(IOC_COARSE_STAGES + sync_tap - 1) : 4'(sync_tap - 1);
  assign direct_bit = (async_reg == 4'h0) ? pad_sync_reg : line_reg[async_idx];
  assign delayed_sync_bit = (sync_eff == 3'h0) ? pad_sync_reg : line_reg[sync_idx];
  // Flags a setting pair that straddles the coarse stage
  assign half_mismatch = (async_reg != 4'h0) && (sync_eff != 3'h0) &&
                         ((async_reg > IOC_ASYNC_HALF) != (sync_eff > IOC_SYNC_HALF));
  assign input_direct_out = direct_bit;

  // ****************************************
  // Entering signal inversion
  // ****************************************
  logic [IOC_INV_W-1:0] raw_in;
  logic [IOC_INV_W-1:0] eff_in;
  logic ce_used;

  assign raw_in = {opposite_force_line_in, set_reset_line_in, tri_ce_in, out_ce_in, in_ce_in,
                   out_clk_lower_en_in, out_clk_upper_en_in, in_clk_lower_en_in, in_clk_upper_en_in,
                   drive_control_lower_in, drive_control_upper_in, output_data_lower_in,
                   output_data_upper_in};
  assign eff_in = raw_in ^ inv_reg;
  assign ce_used = ctrl_reg[IOC_CTRL_CE_USED_BIT];

  // ****************************************
  // Storage pairs
  // ****************************************
  logic [IOC_SE_COUNT-1:0] se_d;
  logic [IOC_SE_COUNT-1:0] se_en;
  logic [IOC_SE_COUNT-1:0] se_q;
  logic ce_in_eff;
  logic ce_out_eff;
  logic ce_tri_eff;
  localparam int SE_BUILT = INPUT_ONLY ? 2 : IOC_SE_COUNT;

  // Unused enables count as asserted
  assign ce_in_eff = ce_used ? eff_in[IOC_INV_ICE] : 1'b1;
  assign ce_out_eff = ce_used ? eff_in[IOC_INV_OCE] : 1'b1;
  assign ce_tri_eff = ce_used ? eff_in[IOC_INV_TCE] : 1'b1;
  assign se_d = {eff_in[IOC_INV_TRI_LO], eff_in[IOC_INV_TRI_UP], eff_in[IOC_INV_OUT_LO],
                 eff_in[IOC_INV_OUT_UP], delayed_sync_bit, delayed_sync_bit};
  // Output and drive-control pairs share the upper and lower clock enables
  assign se_en = {eff_in[IOC_INV_OCLK_LO] & ce_tri_eff, eff_in[IOC_INV_OCLK_UP] & ce_tri_eff,
                  eff_in[IOC_INV_OCLK_LO] & ce_out_eff, eff_in[IOC_INV_OCLK_UP] & ce_out_eff,
                  eff_in[IOC_INV_ICLK_LO] & ce_in_eff, eff_in[IOC_INV_ICLK_UP] & ce_in_eff};

  genvar gi;
  generate
    for (gi = 0; gi < IOC_SE_COUNT; gi++) begin : g_store
      if (gi < SE_BUILT) begin : g_on
        ioc_store u_store (
          .clk_in(clk_in),
          .rst_in(rst_in),
          .d_in(se_d[gi]),
          .en_in(se_en[gi]),
          .set_reset_line_in(eff_in[IOC_INV_SR]),
          .opposite_force_line_in(eff_in[IOC_INV_REV]),
          .cfg_in(secfg_reg[gi]),
          .q_out(se_q[gi])
        );
      end else begin : g_off
        assign se_q[gi] = 1'b0;
      end
    end
  endgenerate

  assign input_capture_upper_out = se_q[0];
  assign input_capture_lower_out = se_q[1];

  // ****************************************
  // Output and drive-control multiplexers
  // ****************************************
  logic out_lower_sel;
  logic out_bit;
  logic tri_bit;

  assign out_lower_sel = ctrl_reg[IOC_CTRL_OUT_LOWER_BIT];
  always_comb begin
    if (ctrl_reg[IOC_CTRL_OUT_REG_BIT]) begin
      out_bit = out_lower_sel ? se_q[3] : se_q[2];
    end else begin
      out_bit = out_lower_sel ? eff_in[IOC_INV_OUT_LO] : eff_in[IOC_INV_OUT_UP];
    end
    if (ctrl_reg[IOC_CTRL_TRI_REG_BIT]) begin
      tri_bit = out_lower_sel ? se_q[5] : se_q[4];
    end else begin
      tri_bit = out_lower_sel ? eff_in[IOC_INV_TRI_LO] : eff_in[IOC_INV_TRI_UP];
    end
  end

  // Drive control high means the pad floats
  assign pad_out = INPUT_ONLY ? 1'b0 : out_bit;
  assign pad_oe_out = INPUT_ONLY ? 1'b0 : ~tri_bit;

  // ****************************************
  // APB read and answer
  // ****************************************
  logic [31:0] status_word;

  assign status_word = {24'h000000, INPUT_ONLY, half_mismatch, coarse_use, pad_oe_out,
                        input_capture_lower_out, input_capture_upper_out, pad_sync_reg, locked};
  assign pready_out = 1'b1;
  // Locked configuration writes and unmapped addresses are refused
  assign pslverr_out = psel_in && penable_in && (!addr_known || (pwrite_in && locked && addr_cfg) ||
                       (pwrite_in && paddr_in == IOC_STATUS_ADDR));
  always_comb begin
    prdata_out = 32'h00000000;
    if (psel_in && !pwrite_in) begin
      case (paddr_in)
        IOC_CTRL_ADDR: prdata_out = {24'h000000, ctrl_reg};
        IOC_DELAY_ADDR: prdata_out = {25'h0000000, sync_reg, async_reg};
        IOC_INVERT_ADDR: prdata_out = {19'h00000, inv_reg};
        IOC_SECFG_ADDR: prdata_out = {14'h0000, secfg_reg};
        IOC_STATUS_ADDR: prdata_out = status_word;
        default: prdata_out = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_locked_write;
    locked ##0 (wr_access && paddr_in == IOC_DELAY_ADDR);
  endsequence

  chk_delay_stays_fixed: assert property (s_locked_write |=> $stable(async_reg) && $stable(sync_reg))
    else $error("delay setting changed after lock");
  chk_lock_never_drops: assert property (locked |=> locked)
    else $error("lock released without reset");
  chk_async_zero_bypass: assert property ((async_reg == 4'h0) |-> (input_direct_out == pad_sync_reg))
    else $error("zero direct delay did not bypass");
  chk_async_range: assert property (async_reg <= IOC_ASYNC_MAX)
    else $error("direct delay setting out of range");
  chk_sync_tap_even: assert property (sync_tap[0] == 1'b0 && sync_tap <= 3'h6)
    else $error("registered route used an odd tap");
  chk_coarse_shared: assert property ((async_reg > IOC_ASYNC_HALF) |-> coarse_use)
    else $error("coarse stage split between routes");
  chk_pad_delay_walk: assert property ((async_reg == 4'h1 && !coarse_use) ##0 $changed(pad_sync_reg)
    |=> $changed(input_direct_out))
    else $error("one tap delay not one cycle");
  chk_tri_direct_oe: assert property ((!INPUT_ONLY && !ctrl_reg[IOC_CTRL_TRI_REG_BIT] && !out_lower_sel)
    |-> (pad_oe_out == ~eff_in[IOC_INV_TRI_UP]))
    else $error("direct drive control not on driver");
  chk_out_direct_data: assert property ((!INPUT_ONLY && !ctrl_reg[IOC_CTRL_OUT_REG_BIT] && !out_lower_sel)
    |-> (pad_out == eff_in[IOC_INV_OUT_UP]))
    else $error("direct output data not on pad");
  chk_input_only_quiet: assert property (INPUT_ONLY |-> (!pad_oe_out && !pad_out))
    else $error("input-only cell drives pad");
  chk_ce_default_on: assert property (!ce_used |-> (ce_in_eff && ce_out_eff && ce_tri_eff))
    else $error("unused enable not asserted");
endmodule
`default_nettype wire

// ### ioc_pad_model.sv
`default_nettype none
module ioc_pad_model (
  input wire logic clk_in,
  input wire logic pad_out_in,
  input wire logic pad_oe_in,
  input wire logic drv_en_in,
  input wire logic drv_val_in,
  output logic level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_reg = 1'b0;
  // ****************************************
  // Pin level
  // ****************************************
  // Floating pin toggles, so a stale level never passes for a driven one
  always_comb begin
    if (pad_oe_in)
      level_out = pad_out_in;
    else if (drv_en_in)
      level_out = drv_val_in;
    else
      level_out = ~last_reg;
  end
  always @(posedge clk_in) begin
    last_reg <= level_out;
  end
endmodule
`default_nettype wire

// ### ioc_cell_tb.sv
`default_nettype none
module ioc_cell_tb
  import ioc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd, t;
  logic pready, pslverr, er, pad_in, pad_out, pad_oe, io_pad, io_oe, idir, cap_up, cap_lo;
  logic [3:0] fab = 4'h4;
  logic [3:0] strb = 4'h0;
  logic [2:0] ce = 3'h0;
  logic sr = 1'b0;
  logic opposite_force_line = 1'b0;
  logic drv_en = 1'b0;
  logic drv_val = 1'b0;
  logic [3:0] f;
  logic [31:0] seed = 32'h10;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int n, s;
  // Force table rows: set-high choice, set/reset, opposite force, expected
  localparam logic [3:0] FRC [6] = '{4'h4, 4'h3, 4'h6, 4'hd, 4'ha, 4'he};

  always #25 clk_in = ~clk_in;

  ioc_cell u_dut (.clk_in(clk_in), .rst_in(rst_in), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe), .output_data_upper_in(fab[0]),
    .output_data_lower_in(fab[1]), .drive_control_upper_in(fab[2]), .drive_control_lower_in(fab[3]),
    .in_clk_upper_en_in(strb[0]), .in_clk_lower_en_in(strb[1]), .out_clk_upper_en_in(strb[2]),
    .out_clk_lower_en_in(strb[3]), .in_ce_in(ce[0]), .out_ce_in(ce[1]), .tri_ce_in(ce[2]),
    .set_reset_line_in(sr), .opposite_force_line_in(opposite_force_line), .input_direct_out(idir),
    .input_capture_upper_out(cap_up), .input_capture_lower_out(cap_lo));
  ioc_cell #(.INPUT_ONLY(1'b1)) u_in_only (.clk_in(clk_in), .rst_in(rst_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(), .pready_out(), .pslverr_out(),
    .pad_in(pad_in), .pad_out(io_pad), .pad_oe_out(io_oe), .output_data_upper_in(fab[0]),
    .output_data_lower_in(fab[1]), .drive_control_upper_in(fab[2]), .drive_control_lower_in(fab[3]),
    .in_clk_upper_en_in(strb[0]), .in_clk_lower_en_in(strb[1]), .out_clk_upper_en_in(strb[2]),
    .out_clk_lower_en_in(strb[3]), .in_ce_in(ce[0]), .out_ce_in(ce[1]), .tri_ce_in(ce[2]),
    .set_reset_line_in(sr), .opposite_force_line_in(opposite_force_line), .input_direct_out(), .input_capture_upper_out(),
    .input_capture_lower_out());
  ioc_pad_model u_pad (.clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe), .drv_en_in(drv_en),
    .drv_val_in(drv_val), .level_out(pad_in));

  // ****************************************
  // Reference model and helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Edges from pad change to direct output: two sync edges, then the taps
  function automatic int dir_lat(int a);
    if (a > 12) a = 12;
    return (a == 0) ? 2 : (a <= 6) ? 2 + a : a;
  endfunction
  // Registered route also waits one capture edge
  function automatic int cap_lat(int v);
    if (v == int'(IOC_SYNC_AUTO)) v = int'(IOC_SYNC_AUTO_STEP);
    return 3 + ((v <= 3) ? 2 * v : 4 + 2 * (v - 3));
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic eer);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
    check({nm, "_err"}, {31'h0, er}, {31'h0, eer});
  endtask
  task automatic meas(input logic cap, output int cnt);
    logic [31:0] r;
    logic v;
    r = xs();
    v = r[0];
    @(posedge clk_in);
    drv_val <= ~v;
    repeat (30) @(posedge clk_in);
    drv_val <= v;
    cnt = 0;
    do begin
      @(posedge clk_in);
      #1;
      cnt++;
    end while (((cap ? cap_up : idir) !== v) && cnt < 40);
  endtask
  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run needs about 1250 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rchk("ctrl", IOC_CTRL_ADDR, 32'h0, 1'b0);
    rchk("delay", IOC_DELAY_ADDR, {25'h0, IOC_SYNC_RST, IOC_ASYNC_RST}, 1'b0);
    rchk("invert", IOC_INVERT_ADDR, 32'h0, 1'b0);
    rchk("secfg", IOC_SECFG_ADDR, 32'h0, 1'b0);
    rchk("unmapped", 8'h14, 32'h0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      t = xs();
      wr(IOC_INVERT_ADDR, {28'h0, t[3:0]});
      wr(IOC_CTRL_ADDR, {27'h0, t[4], 4'h0});
      fab <= t[11:8];
      repeat (2) @(posedge clk_in);
      #1;
      check("pad_out", pad_out, t[4] ? t[9] ^ t[1] : t[8] ^ t[0]);
      check("pad_oe", pad_oe, !(t[4] ? t[11] ^ t[3] : t[10] ^ t[2]));
    end
    wr(IOC_INVERT_ADDR, 32'h0);
    wr(IOC_CTRL_ADDR, 32'h0c);
    fab <= 4'h5;
    repeat (3) @(posedge clk_in);
    #1;
    check("pad_out_held", pad_out, 32'h0);
    check("pad_oe_held", pad_oe, 32'h1);
    check("io_pad", io_pad, 32'h0);
    check("io_oe", io_oe, 32'h0);
    @(posedge clk_in);
    strb <= 4'h4;
    @(posedge clk_in);
    strb <= 4'h0;
    #1;
    check("pad_out_reg", pad_out, 32'h1);
    check("pad_oe_reg", pad_oe, 32'h0);
    wr(IOC_CTRL_ADDR, 32'h1c);
    fab <= 4'ha;
    @(posedge clk_in);
    strb <= 4'h8;
    @(posedge clk_in);
    strb <= 4'h0;
    fab <= 4'h5;
    #1;
    check("pad_out_lower", pad_out, 32'h1);
    check("pad_oe_lower", pad_oe, 32'h0);
    wr(IOC_CTRL_ADDR, 32'h0);
    drv_en <= 1'b1;
    for (int a = 0; a < 14; a++) begin
      s = (a > 6) ? 4 : 1;
      wr(IOC_DELAY_ADDR, 32'(s * 16 + a));
      rchk("delay_rb", IOC_DELAY_ADDR, 32'(s * 16 + ((a > 12) ? 12 : a)), 1'b0);
      meas(1'b0, n);
      check("direct_lat", 32'(n), 32'(dir_lat(a)));
    end
    // Capture enable stays low: unused enable must not block capture
    strb <= 4'h3;
    for (int v = 0; v < 8; v++) begin
      wr(IOC_DELAY_ADDR, 32'(v * 16));
      meas(1'b1, n);
      check("capture_lat", 32'(n), 32'(cap_lat(v)));
      check("capture_lower", cap_lo, drv_val);
    end
    strb <= 4'h0;
    for (int i = 0; i < 6; i++) begin
      f = FRC[i];
      wr(IOC_SECFG_ADDR, {31'h0, f[3]});
      sr <= f[2];
      opposite_force_line <= f[1];
      repeat (2) @(posedge clk_in);
      #1;
      check("force", cap_up, f[0]);
      @(posedge clk_in);
      sr <= 1'b0;
      opposite_force_line <= 1'b0;
    end
    wr(IOC_SECFG_ADDR, 32'h0);
    wr(IOC_CTRL_ADDR, 32'h20);
    strb <= 4'h1;
    drv_val <= 1'b1;
    repeat (30) @(posedge clk_in);
    #1;
    check("ce_block", cap_up, 32'h0);
    wr(IOC_INVERT_ADDR, 32'h100);
    repeat (30) @(posedge clk_in);
    #1;
    check("ce_invert", cap_up, 32'h1);
    // Latch passes data one edge before a flop would
    wr(IOC_SECFG_ADDR, 32'h4);
    meas(1'b1, n);
    check("latch_lat", 32'(n), 32'(cap_lat(7) - 1));
    @(posedge clk_in);
    strb <= 4'h0;
    wr(IOC_SECFG_ADDR, {30'h0, 1'b1, ~drv_val});
    sr <= 1'b1;
    #1;
    check("sync_force_wait", cap_up, drv_val);
    @(posedge clk_in);
    #1;
    check("sync_force", cap_up, !drv_val);
    @(posedge clk_in);
    sr <= 1'b0;
    wr(IOC_CTRL_ADDR, 32'h01);
    wr(IOC_DELAY_ADDR, 32'h05);
    check("lock_err", {31'h0, er}, 32'h1);
    rchk("delay_locked", IOC_DELAY_ADDR, 32'h70, 1'b0);
    wr(IOC_CTRL_ADDR, 32'h04);
    check("route_err", {31'h0, er}, 32'h1);
    rchk("ctrl_locked", IOC_CTRL_ADDR, 32'h01, 1'b0);
    apb(1'b0, IOC_STATUS_ADDR, 32'h0);
    check("status", rd & 32'hf7, {29'h0, !drv_val, drv_val, 1'b1});
    // Only reset reopens configuration
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rchk("ctrl_reset", IOC_CTRL_ADDR, 32'h0, 1'b0);
    rchk("delay_reset", IOC_DELAY_ADDR, {25'h0, IOC_SYNC_RST, IOC_ASYNC_RST}, 1'b0);
    wr(IOC_DELAY_ADDR, 32'h05);
    check("unlock_err", {31'h0, er}, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
